// ==== logic/sps_pkg.sv ====
package sps_pkg;

   // ==========================================================
   // Sizes and clock
   localparam int unsigned SPS_CLK_MHZ = 250;
   localparam int unsigned SPS_NOUT = 12;
   localparam int unsigned SPS_NMON = 12;
   localparam int unsigned SPS_NCP = 6;
   localparam int unsigned SPS_NTRK = 4;
   localparam int unsigned SPS_TMR_W = 32;
   localparam int unsigned SPS_NREG = 24;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] SPS_A_RST_TMO = 8'h19;
   localparam logic [7:0] SPS_A_DRV_LO = 8'h1F;
   localparam logic [7:0] SPS_A_DRV_HI = 8'h22;
   localparam logic [7:0] SPS_A_SW_EN = 8'h4D;
   localparam logic [7:0] SPS_A_FLT_CFG = 8'h4E;
   localparam logic [7:0] SPS_A_DLY_LO = 8'h50;
   localparam logic [7:0] SPS_A_DLY_HI = 8'h54;
   localparam logic [7:0] SPS_A_MON_LO = 8'h56;
   localparam logic [7:0] SPS_A_MON_HI = 8'h5B;
   localparam logic [7:0] SPS_A_ENS_LO = 8'h5E;
   localparam logic [7:0] SPS_A_ENS_HI = 8'h63;
   localparam logic [7:0] SPS_A_STATUS = 8'h70;

   // Storage indices of the register file
   localparam logic [4:0] SPS_I_RST_TMO = 5'h00;
   localparam logic [4:0] SPS_I_DRV = 5'h01;
   localparam logic [4:0] SPS_I_SW_EN = 5'h05;
   localparam logic [4:0] SPS_I_FLT_CFG = 5'h06;
   localparam logic [4:0] SPS_I_DLY = 5'h07;
   localparam logic [4:0] SPS_I_DLY_TOP = 5'h0B;
   localparam logic [4:0] SPS_I_MON = 5'h0C;
   localparam logic [4:0] SPS_I_ENS = 5'h12;

   // ==========================================================
   // Fields
   localparam logic [7:0] SPS_REG_RST = 8'h00;
   localparam logic [7:0] SPS_DRV_HI_MASK = 8'h3F;
   localparam int unsigned SPS_RST_TMO_LSB = 4;
   localparam int unsigned SPS_SW_DIS_BIT = 0;
   localparam int unsigned SPS_PU_FLT_LSB = 0;
   localparam int unsigned SPS_REV_BIT = 4;
   localparam int unsigned SPS_DLY12_LSB = 5;
   localparam int unsigned SPS_DLY_W = 3;
   localparam int unsigned SPS_CODE_W = 4;
   localparam int unsigned SPS_DRV6_W = 3;
   localparam int unsigned SPS_DRV_LO_W = 2;
   localparam int unsigned SPS_DRV_POL_BIT = 0;
   localparam int unsigned SPS_DRV_PP_BIT = 1;
   localparam int unsigned SPS_ST_SLOT_LSB = 0;
   localparam int unsigned SPS_ST_PG_BIT = 4;
   localparam int unsigned SPS_ST_FLT_BIT = 5;
   localparam int unsigned SPS_ST_DOWN_BIT = 6;
   localparam int unsigned SPS_ST_RSTN_BIT = 7;

   // Slot numbers and slot codes
   localparam logic [3:0] SPS_SLOT_FIRST = 4'h0;
   localparam logic [3:0] SPS_SLOT_LAST_OUT = 4'hB;
   localparam logic [3:0] SPS_SLOT_LAST = 4'hC;
   localparam logic [3:0] SPS_CODE_NONE = 4'h0;
   localparam logic [3:0] SPS_CODE_MAX = 4'hC;

   typedef enum logic [2:0] {
      SPS_DRV_OD_LO = 3'h0,
      SPS_DRV_OD_HI = 3'h1,
      SPS_DRV_PP_LO = 3'h2,
      SPS_DRV_PP_HI = 3'h3,
      SPS_DRV_TRK = 3'h4,
      SPS_DRV_CP = 3'h5
   } sps_drv_t;

   typedef enum logic [4:0] {
      SPS_ST_OFF = 5'h01,
      SPS_ST_SLOT = 5'h02,
      SPS_ST_ON = 5'h04,
      SPS_ST_FAULT = 5'h08,
      SPS_ST_DOWN = 5'h10
   } sps_state_t;

   // ==========================================================
   // Times in microseconds and their cycle counts
   typedef int unsigned sps_tbl8_t [8];
   typedef int unsigned sps_tbl4_t [4];

   localparam sps_tbl8_t SPS_SEQ_DLY_US =
      '{20, 12500, 25000, 50000, 100000, 200000, 400000, 1600000};
   localparam sps_tbl4_t SPS_PU_FLT_US = '{25000, 50000, 100000, 200000};
   localparam sps_tbl8_t SPS_RST_TMO_US =
      '{25, 1500, 2500, 5000, 20000, 80000, 160000, 640000};

   // Cycles per microsecond equal the clock rate in MHz
   function automatic int unsigned sps_cyc(int unsigned us);
      int unsigned c;
      c = us * SPS_CLK_MHZ;
      return (c == 0) ? 1 : c;
   endfunction

   function automatic sps_tbl8_t sps_cyc8(sps_tbl8_t us);
      sps_tbl8_t r;
      for (int i = 0; i < 8; i++) begin
         r[i] = sps_cyc(us[i]);
      end
      return r;
   endfunction

   function automatic sps_tbl4_t sps_cyc4(sps_tbl4_t us);
      sps_tbl4_t r;
      for (int i = 0; i < 4; i++) begin
         r[i] = sps_cyc(us[i]);
      end
      return r;
   endfunction

endpackage

// ==== logic/sps_tmr_if.sv ====
`timescale 1ns/1ps
interface sps_tmr_if #(parameter int unsigned W = 32);
   logic load;
   logic [W-1:0] value;
   logic done;
   modport ctl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface

// ==== logic/sps_timer.sv ====
`timescale 1ns/1ps
module sps_timer #(
   parameter int unsigned W = 32
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   // Timer port
   sps_tmr_if.tmr t
);
   localparam logic [W-1:0] ONE = W'(1);
   logic [W-1:0] cnt;

   // Done stays high until the next load, so late readers still see it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt <= '0;
         t.done <= 1'h0;
      end else if (ce) begin
         if (t.load) begin
            cnt <= t.value;
            t.done <= 1'h0;
         end else if (cnt > ONE) begin
            cnt <= cnt - ONE;
         end else if (cnt == ONE) begin
            cnt <= '0;
            t.done <= 1'h1;
         end
      end
   end
endmodule

// ==== logic/sps_en_drive.sv ====
`timescale 1ns/1ps
module sps_en_drive
   import sps_pkg::*;
#(
   parameter bit HAS_CP = 1'h0,
   parameter bit HAS_TRK = 1'h0
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic supply_ok,
   // Request and mode
   input wire logic on,
   input wire logic [2:0] mode,
   // Pin and analog drive enables
   output logic pin_o,
   output logic pin_oe_n,
   output logic pump_en,
   output logic trk_en
);
   logic next_o;
   logic next_oe_n;
   logic next_pump;
   logic next_trk;
   logic lvl;

   always_comb begin
      next_o = 1'h0;
      next_oe_n = 1'h1;
      next_pump = 1'h0;
      next_trk = 1'h0;
      lvl = ~(on ^ mode[SPS_DRV_POL_BIT]);
      if (supply_ok) begin
         unique case (mode)
            SPS_DRV_OD_LO, SPS_DRV_OD_HI, SPS_DRV_PP_LO, SPS_DRV_PP_HI: begin
               next_o = lvl;
               next_oe_n = mode[SPS_DRV_PP_BIT] ? 1'h0 : lvl;
            end
            SPS_DRV_TRK: begin
               next_trk = HAS_TRK & on;
            end
            SPS_DRV_CP: begin
               next_pump = HAS_CP & on;
            end
            default: begin
               next_oe_n = 1'h1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_o <= 1'h0;
         pin_oe_n <= 1'h1;
         pump_en <= 1'h0;
         trk_en <= 1'h0;
      end else if (ce) begin
         pin_o <= next_o;
         pin_oe_n <= next_oe_n;
         pump_en <= next_pump;
         trk_en <= next_trk;
      end
   end
endmodule

// ==== logic/sps_sequencer.sv ====
`timescale 1ns/1ps
module sps_sequencer
   import sps_pkg::*;
#(
   parameter sps_tbl8_t SEQ_DLY_CYC = sps_cyc8(SPS_SEQ_DLY_US),
   parameter sps_tbl4_t PU_FLT_CYC = sps_cyc4(SPS_PU_FLT_US),
   parameter sps_tbl8_t RST_TMO_CYC = sps_cyc8(SPS_RST_TMO_US)
) (
   // Clock, reset and clock enable
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   // Supply and enable sensing
   input wire logic supply_ok,
   input wire logic en_pin_ok,
   input wire logic [SPS_NMON-1:0] rail_monitor_input,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Enable outputs
   output logic [SPS_NOUT-1:0] en_out,
   output logic [SPS_NOUT-1:0] en_out_oe_n,
   output logic [SPS_NCP-1:0] pump_en,
   output logic [SPS_NTRK-1:0] trk_en,
   // Status
   output logic reset_out_n,
   output logic power_good,
   output logic seq_fault
);

   // ==========================================================
   // Register file
   logic [7:0] cfg [SPS_NREG];
   logic hit;
   logic [4:0] idx;

   always_comb begin
      hit = 1'h1;
      idx = SPS_I_RST_TMO;
      if (reg_addr == SPS_A_RST_TMO) begin
         idx = SPS_I_RST_TMO;
      end else if (reg_addr >= SPS_A_DRV_LO && reg_addr <= SPS_A_DRV_HI) begin
         idx = SPS_I_DRV + 5'(reg_addr - SPS_A_DRV_LO);
      end else if (reg_addr == SPS_A_SW_EN) begin
         idx = SPS_I_SW_EN;
      end else if (reg_addr == SPS_A_FLT_CFG) begin
         idx = SPS_I_FLT_CFG;
      end else if (reg_addr >= SPS_A_DLY_LO && reg_addr <= SPS_A_DLY_HI) begin
         idx = SPS_I_DLY + 5'(reg_addr - SPS_A_DLY_LO);
      end else if (reg_addr >= SPS_A_MON_LO && reg_addr <= SPS_A_MON_HI) begin
         idx = SPS_I_MON + 5'(reg_addr - SPS_A_MON_LO);
      end else if (reg_addr >= SPS_A_ENS_LO && reg_addr <= SPS_A_ENS_HI) begin
         idx = SPS_I_ENS + 5'(reg_addr - SPS_A_ENS_LO);
      end else begin
         hit = 1'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < SPS_NREG; i++) begin
            cfg[i] <= SPS_REG_RST;
         end
      end else if (ce && reg_wr && hit) begin
         // reserved top bits held at zero
         if (reg_addr == SPS_A_DRV_HI) begin
            cfg[idx] <= reg_wdata & SPS_DRV_HI_MASK;
         end else begin
            cfg[idx] <= reg_wdata;
         end
      end
   end

   // ==========================================================
   // Configuration decode
   logic [31:0] drv_bits;
   logic [39:0] dly_bits;
   logic [47:0] mon_bits;
   logic [47:0] ens_bits;
   logic [SPS_DLY_W-1:0] slot_dly [13];
   logic [SPS_CODE_W-1:0] out_code [SPS_NOUT];
   logic [SPS_CODE_W-1:0] mon_code [SPS_NMON];
   logic [2:0] drv_mode [SPS_NOUT];
   logic sw_dis;
   logic rev_mode;
   logic [1:0] pu_flt_sel;
   logic [2:0] rst_sel;

   always_comb begin
      drv_bits = {cfg[SPS_I_DRV + 5'h03], cfg[SPS_I_DRV + 5'h02],
                  cfg[SPS_I_DRV + 5'h01], cfg[SPS_I_DRV]};
      dly_bits = {cfg[SPS_I_DLY + 5'h04], cfg[SPS_I_DLY + 5'h03],
                  cfg[SPS_I_DLY + 5'h02], cfg[SPS_I_DLY + 5'h01], cfg[SPS_I_DLY]};
      mon_bits = {cfg[SPS_I_MON + 5'h05], cfg[SPS_I_MON + 5'h04], cfg[SPS_I_MON + 5'h03],
                  cfg[SPS_I_MON + 5'h02], cfg[SPS_I_MON + 5'h01], cfg[SPS_I_MON]};
      ens_bits = {cfg[SPS_I_ENS + 5'h05], cfg[SPS_I_ENS + 5'h04], cfg[SPS_I_ENS + 5'h03],
                  cfg[SPS_I_ENS + 5'h02], cfg[SPS_I_ENS + 5'h01], cfg[SPS_I_ENS]};
      for (int k = 0; k < 12; k++) begin
         slot_dly[k] = dly_bits[SPS_DLY_W*k +: SPS_DLY_W];
      end
      slot_dly[12] = cfg[SPS_I_DLY_TOP][SPS_DLY12_LSB +: SPS_DLY_W];
      for (int i = 0; i < SPS_NOUT; i++) begin
         out_code[i] = ens_bits[SPS_CODE_W*i +: SPS_CODE_W];
         mon_code[i] = mon_bits[SPS_CODE_W*i +: SPS_CODE_W];
         // wide codes on outputs 1-6, narrow codes beyond
         if (i < SPS_NCP) begin
            drv_mode[i] = drv_bits[SPS_DRV6_W*i +: SPS_DRV6_W];
         end else begin
            drv_mode[i] = {1'h0, drv_bits[SPS_DRV6_W*SPS_NCP + SPS_DRV_LO_W*(i-SPS_NCP)
                                          +: SPS_DRV_LO_W]};
         end
      end
      sw_dis = cfg[SPS_I_SW_EN][SPS_SW_DIS_BIT];
      rev_mode = cfg[SPS_I_DLY_TOP][SPS_REV_BIT];
      pu_flt_sel = cfg[SPS_I_FLT_CFG][SPS_PU_FLT_LSB +: 2];
      rst_sel = cfg[SPS_I_RST_TMO][SPS_RST_TMO_LSB +: 3];
   end

   // ==========================================================
   // Slot membership
   sps_state_t state;
   sps_state_t next_state;
   logic [3:0] slot;
   logic [3:0] next_slot;
   logic [3:0] act_slot;
   logic [SPS_NOUT-1:0] act_mask;
   logic [SPS_NMON-1:0] mon_mask;
   logic pass;
   logic pass_seen;
   logic pass_ok;

   always_comb begin
      for (int i = 0; i < SPS_NOUT; i++) begin
         // output code n means slot n-1
         act_mask[i] = out_code[i] != SPS_CODE_NONE && out_code[i] <= SPS_CODE_MAX
                       && (out_code[i] - 4'h1) == act_slot;
      end
      for (int j = 0; j < SPS_NMON; j++) begin
         // monitor code n means slot n; slot 0 checks none
         mon_mask[j] = mon_code[j] == slot && slot != SPS_SLOT_FIRST;
      end
   end

   assign pass = &(rail_monitor_input | ~mon_mask);
   assign pass_ok = pass | pass_seen;

   // ==========================================================
   // Timers
   sps_tmr_if #(.W(SPS_TMR_W)) seq_t ();
   sps_tmr_if #(.W(SPS_TMR_W)) flt_t ();
   sps_tmr_if #(.W(SPS_TMR_W)) rst_t ();

   sps_timer #(.W(SPS_TMR_W)) u_seq_tmr (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .t(seq_t.tmr));
   sps_timer #(.W(SPS_TMR_W)) u_flt_tmr (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .t(flt_t.tmr));
   sps_timer #(.W(SPS_TMR_W)) u_rst_tmr (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .t(rst_t.tmr));

   // delay of the slot being entered
   assign seq_t.value = SEQ_DLY_CYC[slot_dly[next_slot]];
   assign flt_t.value = PU_FLT_CYC[pu_flt_sel];
   assign rst_t.value = RST_TMO_CYC[rst_sel];
   assign flt_t.load = seq_t.load;
   // first slot 12 pass starts the reset timeout
   assign rst_t.load = state == SPS_ST_SLOT && slot == SPS_SLOT_LAST && pass && !pass_seen;

   // ==========================================================
   // Sequencer state machine
   logic pdn_req;
   logic set_on;
   logic clr_on;
   logic clr_all;
   logic set_fault;

   // enable pin low or software bit set
   assign pdn_req = !en_pin_ok || sw_dis;

   always_comb begin
      next_state = state;
      next_slot = slot;
      act_slot = slot;
      seq_t.load = 1'h0;
      set_on = 1'h0;
      clr_on = 1'h0;
      clr_all = 1'h0;
      set_fault = 1'h0;
      unique case (state)
         SPS_ST_OFF: begin
            // slot 0 waits for pin and bit
            if (!pdn_req) begin
               next_state = SPS_ST_SLOT;
               next_slot = SPS_SLOT_FIRST;
               act_slot = SPS_SLOT_FIRST;
               seq_t.load = 1'h1;
               // slot 0 outputs before its delay
               set_on = 1'h1;
            end
         end
         SPS_ST_SLOT: begin
            if (pdn_req) begin
               next_state = SPS_ST_DOWN;
            end else if (seq_t.done && pass_ok) begin
               // slot 1-11 outputs at slot end
               set_on = slot != SPS_SLOT_FIRST && slot != SPS_SLOT_LAST;
               if (slot == SPS_SLOT_LAST) begin
                  next_state = SPS_ST_ON;
               end else begin
                  next_slot = slot + 4'h1;
                  seq_t.load = 1'h1;
               end
            end else if (flt_t.done && !pass_ok) begin
               next_state = SPS_ST_FAULT;
               set_fault = 1'h1;
            end
         end
         SPS_ST_ON, SPS_ST_FAULT: begin
            if (pdn_req) begin
               next_state = SPS_ST_DOWN;
            end
         end
         SPS_ST_DOWN: begin
            if (seq_t.done) begin
               if (slot == SPS_SLOT_FIRST) begin
                  next_state = SPS_ST_OFF;
               end else begin
                  next_slot = slot - 4'h1;
                  act_slot = next_slot;
                  clr_on = 1'h1;
                  seq_t.load = 1'h1;
               end
            end
         end
         default: begin
            next_state = SPS_ST_OFF;
            clr_all = 1'h1;
         end
      endcase
      // Common power-down entry
      if (state != SPS_ST_DOWN && next_state == SPS_ST_DOWN) begin
         set_on = 1'h0;
         if (rev_mode) begin
            next_slot = SPS_SLOT_LAST_OUT;
            act_slot = SPS_SLOT_LAST_OUT;
            clr_on = 1'h1;
            seq_t.load = 1'h1;
         end else begin
            next_state = SPS_ST_OFF;
            next_slot = SPS_SLOT_FIRST;
            clr_all = 1'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= SPS_ST_OFF;
         slot <= SPS_SLOT_FIRST;
      end else if (ce) begin
         state <= next_state;
         slot <= next_slot;
      end
   end

   // pass may come any time inside the window
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pass_seen <= 1'h0;
      end else if (ce) begin
         if (seq_t.load) begin
            pass_seen <= 1'h0;
         end else if (state == SPS_ST_SLOT && pass) begin
            pass_seen <= 1'h1;
         end
      end
   end

   // ==========================================================
   // Output requests
   logic [SPS_NOUT-1:0] on;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         on <= '0;
      end else if (ce) begin
         if (clr_all) begin
            on <= '0;
         end else if (set_on) begin
            // shared slot asserts in one cycle
            on <= on | act_mask;
         end else if (clr_on) begin
            on <= on & ~act_mask;
         end
      end
   end

   logic [SPS_NOUT-1:0] pump_all;
   logic [SPS_NOUT-1:0] trk_all;

   for (genvar g = 0; g < SPS_NOUT; g++) begin : g_drv
      sps_en_drive #(
         .HAS_CP(g < SPS_NCP),
         .HAS_TRK(g < SPS_NTRK)
      ) u_drv (
         .clk_sys(clk_sys),
         .reset(reset),
         .ce(ce),
         .supply_ok(supply_ok),
         .on(on[g]),
         .mode(drv_mode[g]),
         .pin_o(en_out[g]),
         .pin_oe_n(en_out_oe_n[g]),
         .pump_en(pump_all[g]),
         .trk_en(trk_all[g])
      );
   end

   assign pump_en = pump_all[SPS_NCP-1:0];
   assign trk_en = trk_all[SPS_NTRK-1:0];

   // ==========================================================
   // Status outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reset_out_n <= 1'h0;
         power_good <= 1'h0;
         seq_fault <= 1'h0;
      end else if (ce) begin
         // release only after this run's timeout
         reset_out_n <= rst_t.done && pass_seen && next_state != SPS_ST_DOWN
                        && next_state != SPS_ST_OFF
                        && (state == SPS_ST_ON
                            || (state == SPS_ST_SLOT && slot == SPS_SLOT_LAST));
         power_good <= next_state == SPS_ST_ON;
         // fault flag held until the next start
         if (set_fault) begin
            seq_fault <= 1'h1;
         end else if (state == SPS_ST_OFF && next_state == SPS_ST_SLOT) begin
            seq_fault <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd) begin
         if (reg_addr == SPS_A_STATUS) begin
            reg_rdata <= 8'h00;
            reg_rdata[SPS_ST_SLOT_LSB +: 4] <= slot;
            reg_rdata[SPS_ST_PG_BIT] <= power_good;
            reg_rdata[SPS_ST_FLT_BIT] <= seq_fault;
            reg_rdata[SPS_ST_DOWN_BIT] <= state == SPS_ST_DOWN;
            reg_rdata[SPS_ST_RSTN_BIT] <= reset_out_n;
         end else if (hit) begin
            reg_rdata <= cfg[idx];
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

// ==== testbench/sps_sup_model.sv ====
`timescale 1ns/1ps
module sps_sup_model (
   // Pins
   input wire logic clk_sys,
   input wire logic [11:0] en_out,
   input wire logic [11:0] en_out_oe_n,
   input wire logic [11:0] pol,
   input wire logic [11:0] stuck,
   // Rails
   output logic [11:0] rail
);
   logic [2:0] cnt [12] = '{default: 3'h0};
   always_ff @(posedge clk_sys) begin
      for (int j = 0; j < 12; j++) begin
         // Pull-up on a released pin; rail good 6 cycles after turn-on
         cnt[j] <= ((en_out_oe_n[j] | en_out[j]) != pol[j]) ? 3'h0 : cnt[j] + (cnt[j] < 3'h5);
         rail[j] <= cnt[j] == 3'h5 && !stuck[j];
      end
   end
endmodule

// ==== testbench/sps_sequencer_chk.sv ====
`timescale 1ns/1ps
module sps_sequencer_chk
   import sps_pkg::*;
#(
   parameter sps_tbl8_t SEQ_DLY_CYC = sps_cyc8(SPS_SEQ_DLY_US),
   parameter sps_tbl8_t RST_TMO_CYC = sps_cyc8(SPS_RST_TMO_US)
) (
   // Inputs and outputs watched
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic supply_ok,
   input wire logic en_pin_ok,
   input wire logic [SPS_NMON-1:0] rail_monitor_input,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [SPS_NOUT-1:0] en_out_oe_n,
   input wire logic reset_out_n,
   input wire logic power_good,
   input wire logic seq_fault
);
   logic sw;
   int unsigned run, hold;
   always_ff @(posedge clk_sys) begin
      if (reset) sw <= 1'b0;
      else if (ce && reg_wr && reg_addr == SPS_A_SW_EN) sw <= reg_wdata[0];
   end
   // Monitor 12 is the slot 12 rail in the bench
   always_ff @(posedge clk_sys) begin
      run <= (reset || !en_pin_ok || sw) ? 0 : run + 1;
      hold <= rail_monitor_input[11] ? hold + 1 : 0;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_rel; !$past(supply_ok) |-> &en_out_oe_n; endproperty
   a_rel: assert property (p_rel) else $error("pin driven without supply");
   property p_hi; ce && reg_rd && reg_addr == SPS_A_DRV_HI |=> reg_rdata[7:6] == 2'h0; endproperty
   a_hi: assert property (p_hi) else $error("reserved bits read set");
   property p_pg; $rose(power_good) |-> run >= 13 * SEQ_DLY_CYC[0]; endproperty
   a_pg: assert property (p_pg) else $error("power good too early");
   property p_ok; $rose(power_good) |-> !seq_fault && en_pin_ok; endproperty
   a_ok: assert property (p_ok) else $error("power good in bad state");
   property p_rst; $rose(reset_out_n) |-> hold >= RST_TMO_CYC[0]; endproperty
   a_rst: assert property (p_rst) else $error("reset released early");
   property p_flt; seq_fault |-> !power_good && !reset_out_n; endproperty
   a_flt: assert property (p_flt) else $error("fault with power good");
   property p_pin; $fell(en_pin_ok) && reset_out_n |-> ##[1:3] !reset_out_n; endproperty
   a_pin: assert property (p_pin) else $error("no power-down on pin");
   property p_sw;
      ce && reg_wr && reg_addr == SPS_A_SW_EN && reg_wdata[0] && reset_out_n
         |-> ##[1:3] !reset_out_n;
   endproperty
   a_sw: assert property (p_sw) else $error("no power-down on bit");
   c_pg: cover property ($rose(power_good));
   c_flt: cover property ($rose(seq_fault));
   c_rst: cover property ($rose(reset_out_n));
endmodule
bind sps_sequencer sps_sequencer_chk #(.SEQ_DLY_CYC(SEQ_DLY_CYC), .RST_TMO_CYC(RST_TMO_CYC))
   u_chk (
   .clk_sys(clk_sys), .reset(reset), .ce(ce), .supply_ok(supply_ok), .en_pin_ok(en_pin_ok),
   .rail_monitor_input(rail_monitor_input), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .en_out_oe_n(en_out_oe_n),
   .reset_out_n(reset_out_n), .power_good(power_good), .seq_fault(seq_fault));

// ==== testbench/sps_sequencer_tb.sv ====
`timescale 1ns/1ps
module sps_sequencer_tb
   import sps_pkg::*;
;
   localparam int unsigned D = 20;
   logic clk_sys = 1'b0, reset = 1'b1, supply_ok = 1'b0, en_pin_ok = 1'b0, ce = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, reset_out_n, power_good, seq_fault;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
   logic [11:0] en_out, oe_n, rail, stuck = 12'h000, prv = 12'h000;
   logic [5:0] pump_en, hc;
   logic [3:0] trk_en;
   int bad_count = 0, tests_run = 0, cyc = 0, t0, g;
   int tr [12], tf [12];
   always #2 clk_sys = ~clk_sys;
   sps_sequencer #(.SEQ_DLY_CYC('{default: D}), .PU_FLT_CYC('{default: 40}),
      .RST_TMO_CYC('{default: 30})) u_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce),
      .supply_ok(supply_ok), .en_pin_ok(en_pin_ok), .rail_monitor_input(rail),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .en_out(en_out), .en_out_oe_n(oe_n), .pump_en(pump_en),
      .trk_en(trk_en), .reset_out_n(reset_out_n), .power_good(power_good), .seq_fault(seq_fault));
   sps_sup_model u_sup (.clk_sys(clk_sys), .en_out(en_out), .en_out_oe_n(oe_n),
      .pol({hc[4], hc[2], hc[0], 9'h1FF}), .stuck(stuck), .rail(rail));
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      prv <= en_out;
      for (int i = 0; i < 12; i++) begin
         if (en_out[i] && !prv[i]) tr[i] = cyc;
         if (!en_out[i] && prv[i]) tf[i] = cyc;
      end
   end
   // =====================
   // Expectations and tasks
   function automatic logic [5:0] drv(input logic [5:0] c, input logic on);
      for (int k = 0; k < 3; k++) begin
         drv[k + 3] = !c[2*k+1] && (c[2*k] == on);
         drv[k] = !drv[k + 3] && (on ~^ c[2*k]);
      end
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      tk(1);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      rv = reg_rdata;
      tk(1);
   endtask
   task automatic wt(input bit f);
      for (int k = 0; k < 2000 && (f ? seq_fault : power_good) !== 1'b1; k++) tk(1);
      chk(f ? seq_fault : power_good, 1'b1);
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #40000;
      bad_count++;
      give_verdict();
   end
   initial begin
      hc = 6'($urandom(18865));
      tk(2);
      reset <= 1'b0;
      acc(1, SPS_A_DRV_HI, {2'h3, hc});
      acc(0, SPS_A_DRV_HI, 8'h00);
      chk(rv, {2'h0, hc});
      acc(0, 8'h23, 8'h00);
      chk(rv, 8'h00);
      for (int k = 0; k < 3; k++) acc(1, 8'(SPS_A_DRV_LO + k), 8'(32'hFDB6DB >> 8 * k));
      for (int k = 0; k < 6; k++) begin
         acc(1, 8'(SPS_A_MON_LO + k), {4'(2 * k + 2), 4'(2 * k + 1)});
         acc(1, 8'(SPS_A_ENS_LO + k), {k ? 4'(2 * k + 2) : 4'h1, 4'(2 * k + 1)});
      end
      for (int k = 0; k < 4; k++) acc(1, 8'(SPS_A_DLY_LO + k), 8'($urandom));
      acc(1, SPS_A_DLY_HI, 8'($urandom) | 8'h10);
      acc(1, SPS_A_RST_TMO, 8'($urandom));
      acc(1, SPS_A_FLT_CFG, 8'($urandom));
      chk(oe_n, 12'hFFF);
      supply_ok <= 1'b1;
      tk(2);
      chk({oe_n[8:0], en_out[8:0]}, 18'h0);
      chk({oe_n[11:9], en_out[11:9] & ~oe_n[11:9]}, drv(hc, 1'b0));
      // Frozen clock enable: no start, write dropped
      ce <= 1'b0;
      en_pin_ok <= 1'b1;
      acc(1, SPS_A_SW_EN, 8'h01);
      chk(en_out[1:0], 2'h0);
      ce <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         en_pin_ok <= 1'b1;
         t0 = cyc;
         wt(0);
         chk(tr[0] - t0 < 4, 1'b1);
         for (int i = 1; i < 9; i++) begin
            // Slot 0 outputs lead slot 2 ones by three delays
            g = (i == 1) ? 0 : (i == 2) ? 3 * D : D;
            chk(tr[i] - tr[i-1] >= g && tr[i] - tr[i-1] <= g + g / 5, 1'b1);
         end
         tk(40);
         chk({reset_out_n, seq_fault}, 2'h2);
         chk({oe_n[11:9], en_out[11:9] & ~oe_n[11:9]}, drv(hc, 1'b1));
         chk({pump_en, trk_en}, 10'h000);
         if (p == 0) begin
            en_pin_ok <= 1'b0;
            tk(14 * D);
            for (int i = 1; i < 9; i++) begin
               g = (i == 1) ? 0 : (i == 2) ? 2 * D : D;
               chk(tf[i-1] - tf[i] >= g && tf[i-1] - tf[i] <= g + g / 5, 1'b1);
            end
         end
      end
      acc(1, SPS_A_DLY_HI, 8'($urandom) & 8'hEF);
      acc(1, SPS_A_SW_EN, 8'h01);
      tk(30);
      for (int i = 1; i < 9; i++) chk(tf[i], tf[0]);
      chk(en_out[8:0], 9'h0);
      stuck <= 12'h010;
      acc(1, SPS_A_SW_EN, 8'h00);
      wt(1);
      tk(2 * D);
      chk({power_good, en_out[5:4]}, 3'h1);
      give_verdict();
   end
endmodule
